/* File: src/imu_i2c_target.sv */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "imu_i2c_params.svh"

module imu_i2c_target #(
  parameter int PTR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic link_clk,
  imu_i2c_if.tgt bus,
  input wire logic accel_addr_select,
  input wire logic gyro_addr_select,
  input wire logic accel_chip_select_n,
  input wire logic gyro_protocol_select,
  output logic wr_valid,
  output logic wr_part,
  output logic [PTR_W-1:0] wr_addr,
  output imu_i2c_pkg::imu_byte_t wr_data,
  output logic bus_busy,
  output logic accel_spi_mode
);
  import imu_i2c_pkg::*;

  localparam int MEM_D = 2 ** PTR_W;

  // ==========================================================
  // Pin synchronisers on the link clock
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic l_rst_b;
  logic l_ce;
  logic scl_s;
  logic sda_s;
  logic asel_s;
  logic gsel_s;
  logic cs_n_s;
  logic ps_s;

  // Reset and enable cross too, so no link flop sees a raw clk-domain level
  always_ff @(posedge link_clk)
  begin
    pin_s1_r <= {rst_b, ce, bus.scl, bus.sda, accel_addr_select, gyro_addr_select,
                 accel_chip_select_n, gyro_protocol_select};
    pin_s2_r <= pin_s1_r;
  end

  assign l_rst_b = pin_s2_r[7];
  assign l_ce = pin_s2_r[6];
  assign scl_s = pin_s2_r[5];
  assign sda_s = pin_s2_r[4];
  assign asel_s = pin_s2_r[3];
  assign gsel_s = pin_s2_r[2];
  assign cs_n_s = pin_s2_r[1];
  assign ps_s = pin_s2_r[0];

  // ==========================================================
  // Bus events
  logic scl_q_r;
  logic sda_q_r;
  logic cs_q_r;
  logic acc_spi_r;
  logic toggled_r;
  logic busy_r;
  logic start_ev;
  logic stop_ok;
  logic scl_rise;
  logic scl_fall;

  assign start_ev = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_ok = scl_s & scl_q_r & ~sda_q_r & sda_s & toggled_r;
  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;

  // Previous levels, SPI lock and bus-busy tracking
  always_ff @(posedge link_clk)
  begin
    if (!l_rst_b)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cs_q_r <= 1'b1;
      acc_spi_r <= 1'b0;
      toggled_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else if (l_ce)
    begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      cs_q_r <= cs_n_s;
      if (cs_n_s && !cs_q_r)
        acc_spi_r <= 1'b1;
      if (start_ev)
        toggled_r <= 1'b0;
      else if (scl_fall)
        toggled_r <= 1'b1;
      if (start_ev)
        busy_r <= 1'b1;
      else if (stop_ok)
        busy_r <= 1'b0;
    end
  end

  // ==========================================================
  // Byte engine
  imu_tgt_state_e state_r;
  logic [3:0] cnt_r;
  logic ack_ph_r;
  logic sda_oe_r;
  logic [7:0] shift_r;
  logic [7:0] tx_sh_r;
  logic part_r;
  logic rw_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W-1:0] base_r [2];
  logic [7:0] mem_r [2][MEM_D];
  logic [6:0] acc_addr;
  logic [6:0] gyr_addr;
  logic hit_acc;
  logic hit_gyr;
  logic rx_st;
  logic byte_end;
  logic act;
  logic mem_we;
  logic base_we;
  logic [PTR_W-1:0] rd_src;
  logic [7:0] rd_byte;

  assign acc_addr = asel_s ? `IMU_ACC_ADDR_HI : `IMU_ACC_ADDR_LO;
  assign gyr_addr = gsel_s ? `IMU_GYR_ADDR_HI : `IMU_GYR_ADDR_LO;
  // Only a 7-bit compare: a 10-bit header never matches
  assign hit_acc = ~acc_spi_r & (shift_r[7:1] == acc_addr);
  assign hit_gyr = ps_s & (shift_r[7:1] == gyr_addr);
  assign rx_st = (state_r == IMU_T_ADDR) | (state_r == IMU_T_REG) | (state_r == IMU_T_DATA);
  assign byte_end = rx_st & ~ack_ph_r & scl_fall & (cnt_r == 4'h8);
  assign act = l_ce & ~start_ev & ~stop_ok;
  assign mem_we = act & byte_end & (state_r == IMU_T_DATA);
  assign base_we = act & byte_end & (state_r == IMU_T_REG);
  // First byte of a read comes from the last written address
  assign rd_src = (state_r == IMU_T_ADDR) ? base_r[part_r] : rd_ptr_r;
  assign rd_byte = mem_r[part_r][rd_src];

  // Protocol sequencer; start and stop override any state
  always_ff @(posedge link_clk)
  begin
    if (!l_rst_b)
    begin
      state_r <= IMU_T_IDLE;
      cnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      sda_oe_r <= 1'b0;
      shift_r <= 8'h00;
      tx_sh_r <= 8'h00;
      part_r <= 1'b0;
      rw_r <= 1'b0;
      rd_ptr_r <= '0;
    end
    else if (l_ce)
    begin
      if (start_ev)
      begin
        state_r <= IMU_T_ADDR;
        cnt_r <= 4'h0;
        ack_ph_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else if (stop_ok)
      begin
        state_r <= IMU_T_IDLE;
        ack_ph_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else
      begin
        unique case (state_r)
          IMU_T_IDLE, IMU_T_WAIT:
          begin
          end
          IMU_T_ADDR, IMU_T_REG, IMU_T_DATA:
          begin
            if (!ack_ph_r && scl_rise)
            begin
              shift_r <= {shift_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end
            else if (byte_end)
            begin
              cnt_r <= 4'h0;
              if (state_r != IMU_T_ADDR || hit_acc || hit_gyr)
              begin
                ack_ph_r <= 1'b1;
                sda_oe_r <= 1'b1;
              end
              else
                state_r <= IMU_T_WAIT;
              if (state_r == IMU_T_ADDR)
              begin
                part_r <= hit_gyr;
                rw_r <= shift_r[0];
              end
            end
            else if (ack_ph_r && scl_fall)
            begin
              ack_ph_r <= 1'b0;
              if (state_r == IMU_T_ADDR && rw_r)
              begin
                state_r <= IMU_T_TX;
                tx_sh_r <= rd_byte;
                sda_oe_r <= ~rd_byte[7];
                rd_ptr_r <= rd_src + 1'b1;
              end
              else
              begin
                sda_oe_r <= 1'b0;
                if (state_r == IMU_T_ADDR)
                  state_r <= IMU_T_REG;
                else if (state_r == IMU_T_REG)
                  state_r <= IMU_T_DATA;
                else
                  state_r <= IMU_T_WAIT;
              end
            end
          end
          IMU_T_TX:
          begin
            if (scl_rise && !ack_ph_r)
              cnt_r <= cnt_r + 4'h1;
            else if (scl_rise && sda_s)
              state_r <= IMU_T_WAIT;
            else if (scl_fall && !ack_ph_r && cnt_r == 4'h8)
            begin
              sda_oe_r <= 1'b0;
              ack_ph_r <= 1'b1;
            end
            else if (scl_fall && !ack_ph_r)
            begin
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              sda_oe_r <= ~tx_sh_r[6];
            end
            else if (scl_fall)
            begin
              ack_ph_r <= 1'b0;
              cnt_r <= 4'h0;
              tx_sh_r <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              rd_ptr_r <= rd_src + 1'b1;
            end
          end
          default:
            state_r <= IMU_T_IDLE;
        endcase
      end
    end
  end

  // Open drain: the pad only ever pulls low
  assign bus.tgt_sda_oe = sda_oe_r;
  assign bus.tgt_sda_out = 1'b0;

  // ==========================================================
  // Register storage and write notification
  logic wr_tgl_r;
  logic wr_part_l_r;
  logic [PTR_W-1:0] wr_addr_l_r;
  logic [7:0] wr_data_l_r;

  // One stored byte per write, at that sequence's register address
  always_ff @(posedge link_clk)
  begin
    if (!l_rst_b)
    begin
      for (int p = 0; p < 2; p++)
        for (int a = 0; a < MEM_D; a++)
          mem_r[p][a] <= 8'h00;
      for (int p = 0; p < 2; p++)
        base_r[p] <= PTR_W'(`IMU_PTR_RST);
      wr_tgl_r <= 1'b0;
      wr_part_l_r <= 1'b0;
      wr_addr_l_r <= '0;
      wr_data_l_r <= 8'h00;
    end
    else
    begin
      if (base_we)
        base_r[part_r] <= shift_r[PTR_W-1:0];
      if (mem_we)
      begin
        mem_r[part_r][base_r[part_r]] <= shift_r;
        wr_tgl_r <= ~wr_tgl_r;
        wr_part_l_r <= part_r;
        wr_addr_l_r <= base_r[part_r];
        wr_data_l_r <= shift_r;
      end
    end
  end

  // ==========================================================
  // Crossing to the system clock
  logic [2:0] tgl_sync_r;
  logic [1:0] busy_sync_r;
  logic [1:0] spi_sync_r;

  // Toggle crossing; held words are safe since writes are microseconds apart
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tgl_sync_r <= 3'h0;
      busy_sync_r <= 2'h0;
      spi_sync_r <= 2'h0;
      wr_valid <= 1'b0;
      wr_part <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
      bus_busy <= 1'b0;
      accel_spi_mode <= 1'b0;
    end
    else if (ce)
    begin
      tgl_sync_r <= {tgl_sync_r[1:0], wr_tgl_r};
      busy_sync_r <= {busy_sync_r[0], busy_r};
      spi_sync_r <= {spi_sync_r[0], acc_spi_r};
      wr_valid <= tgl_sync_r[1] ^ tgl_sync_r[2];
      if (tgl_sync_r[1] ^ tgl_sync_r[2])
      begin
        wr_part <= wr_part_l_r;
        wr_addr <= wr_addr_l_r;
        wr_data <= wr_data_l_r;
      end
      bus_busy <= busy_sync_r[1];
      accel_spi_mode <= spi_sync_r[1];
    end
  end
endmodule : imu_i2c_target

/* File: src/imu_i2c_params.svh */
`ifndef IMU_I2C_PARAMS_SVH
`define IMU_I2C_PARAMS_SVH
// What this block does
// - Target in standard/fast mode, 7-bit addresses only
// - Accel answers 0x18, or 0x19 with strap high
// - Gyro answers 0x68, or 0x69 with strap high
// - Controller waits 2 us, suspend 1000 us, between writes
// - Start: SDA falls, SCL high; bus busy
// - Controller ends with stop; target detects it
// - Receiver pulls SDA low on ninth clock
// - Stop straight after start is ignored
// - Write: start, address+0, register, data, stop
// - Exactly one data byte stored per write
// - Read: register write, repeated start, address+1
// - Controller target_ack to continue; nack ends transfer
// - Read pointer advances after each sent byte
// - Reads start at last written address, reset 0x00
// - Gyro uses I2C only when protocol select high
// - Chip-select rising edge locks accel into SPI

// ==========================================================
// Target addresses and pointer reset
`define IMU_ACC_ADDR_LO 7'h18
`define IMU_ACC_ADDR_HI 7'h19
`define IMU_GYR_ADDR_LO 7'h68
`define IMU_GYR_ADDR_HI 7'h69
`define IMU_PTR_RST 8'h00

// ==========================================================
// Timing, figures in their own unit
`define IMU_CLK_NS 25
`define IMU_T_LOW_NS 1300
`define IMU_T_SCL_NS 2500
`define IMU_T_BUF_NS 1300
`define IMU_T_WACC_NM_US 2
`define IMU_T_WACC_SUM_US 1000
`define IMU_LOW_CYC ((`IMU_T_LOW_NS + `IMU_CLK_NS - 1) / `IMU_CLK_NS)
`define IMU_HIGH_CYC ((`IMU_T_SCL_NS + `IMU_CLK_NS - 1) / `IMU_CLK_NS - `IMU_LOW_CYC)
`define IMU_BUF_CYC ((`IMU_T_BUF_NS + `IMU_CLK_NS - 1) / `IMU_CLK_NS)
`define IMU_WACC_NM_CYC ((`IMU_T_WACC_NM_US * 1000 + `IMU_CLK_NS - 1) / `IMU_CLK_NS)
`define IMU_WACC_SUM_CYC ((`IMU_T_WACC_SUM_US * 1000 + `IMU_CLK_NS - 1) / `IMU_CLK_NS)

// ==========================================================
// Controller register map and fields
`define IMU_REG_TARGET 8'h00
`define IMU_REG_PTR 8'h04
`define IMU_REG_WDATA 8'h08
`define IMU_REG_CMD 8'h0c
`define IMU_REG_LEN 8'h10
`define IMU_REG_STATUS 8'h14
`define IMU_REG_RXBUF 8'h40
`define IMU_RXBUF_MASK 8'hc0
`define IMU_CMD_WR_BIT 0
`define IMU_CMD_RD_BIT 1
`define IMU_CMD_SUSP_BIT 2
`define IMU_STAT_BUSY_BIT 0
`define IMU_STAT_NACK_BIT 1

`endif

/* File: src/imu_i2c_pkg.sv */
package imu_i2c_pkg;
  typedef logic [7:0] imu_byte_t;

  // ==========================================================
  // Target end states
  typedef enum logic [2:0] {
    IMU_T_IDLE = 3'b000,
    IMU_T_ADDR = 3'b001,
    IMU_T_REG = 3'b010,
    IMU_T_DATA = 3'b011,
    IMU_T_TX = 3'b100,
    IMU_T_WAIT = 3'b101
  } imu_tgt_state_e;

  // ==========================================================
  // Controller end states
  typedef enum logic [2:0] {
    IMU_C_IDLE = 3'b000,
    IMU_C_START = 3'b001,
    IMU_C_BIT = 3'b010,
    IMU_C_RSTART = 3'b011,
    IMU_C_STOP = 3'b100,
    IMU_C_GAP = 3'b101
  } imu_ctl_state_e;
endpackage : imu_i2c_pkg

/* File: src/imu_i2c_if.sv */
interface imu_i2c_if;
  logic ctl_scl_out;
  logic ctl_scl_oe;
  logic ctl_sda_out;
  logic ctl_sda_oe;
  logic tgt_sda_out;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  // Wired-and with pull-ups: a line is low only while someone drives low
  assign scl = ~(ctl_scl_oe & ~ctl_scl_out);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_out) | (tgt_sda_oe & ~tgt_sda_out));

  modport ctl (
    input scl,
    input sda,
    output ctl_scl_out,
    output ctl_scl_oe,
    output ctl_sda_out,
    output ctl_sda_oe
  );
  modport tgt (
    input scl,
    input sda,
    output tgt_sda_out,
    output tgt_sda_oe
  );
endinterface : imu_i2c_if

/* File: src/imu_i2c_controller.sv */
`include "imu_i2c_params.svh"

module imu_i2c_controller #(
  parameter int WACC_SUM_CYC = `IMU_WACC_SUM_CYC,
  parameter int RXI_W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  imu_i2c_if.ctl bus,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import imu_i2c_pkg::*;

  localparam logic [15:0] LOW_C = 16'(`IMU_LOW_CYC);
  localparam logic [15:0] HIGH_C = 16'(`IMU_HIGH_CYC);
  localparam logic [15:0] BUF_C = 16'(`IMU_BUF_CYC);
  localparam logic [15:0] NM_C = 16'(`IMU_WACC_NM_CYC);
  localparam logic [15:0] SUM_C = 16'(WACC_SUM_CYC);

  // ==========================================================
  // Software registers
  logic [6:0] tgt_r;
  imu_byte_t ptr_r;
  imu_byte_t wdat_r;
  logic [RXI_W-1:0] len_r;
  logic susp_r;
  logic nack_r;
  imu_byte_t rxbuf_r [2 ** RXI_W];
  imu_ctl_state_e state_r;
  logic go_wr;
  logic go_rd;
  logic nack_ev;
  logic [31:0] rd_mux;

  assign go_wr = wr & (addr == `IMU_REG_CMD) & wdata[`IMU_CMD_WR_BIT] & (state_r == IMU_C_IDLE);
  assign go_rd = wr & (addr == `IMU_REG_CMD) & wdata[`IMU_CMD_RD_BIT] & (state_r == IMU_C_IDLE)
                 & ~go_wr;

  // Config writes; a nack in the clearing cycle still sets the flag
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tgt_r <= `IMU_ACC_ADDR_LO;
      ptr_r <= `IMU_PTR_RST;
      wdat_r <= 8'h00;
      len_r <= '0;
      susp_r <= 1'b0;
      nack_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && addr == `IMU_REG_TARGET)
        tgt_r <= wdata[6:0];
      if (wr && addr == `IMU_REG_PTR)
        ptr_r <= wdata[7:0];
      if (wr && addr == `IMU_REG_WDATA)
        wdat_r <= wdata[7:0];
      if (wr && addr == `IMU_REG_LEN)
        len_r <= wdata[RXI_W-1:0];
      if (wr && addr == `IMU_REG_CMD)
        susp_r <= wdata[`IMU_CMD_SUSP_BIT];
      nack_r <= nack_ev | (nack_r & ~(wr && addr == `IMU_REG_STATUS
                                      && wdata[`IMU_STAT_NACK_BIT]));
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if ((addr & `IMU_RXBUF_MASK) == `IMU_REG_RXBUF)
      rd_mux = {24'h00_0000, rxbuf_r[addr[RXI_W+1:2]]};
    else if (addr == `IMU_REG_TARGET)
      rd_mux = {25'h000_0000, tgt_r};
    else if (addr == `IMU_REG_PTR)
      rd_mux = {24'h00_0000, ptr_r};
    else if (addr == `IMU_REG_WDATA)
      rd_mux = {24'h00_0000, wdat_r};
    else if (addr == `IMU_REG_LEN)
      rd_mux = {{(32 - RXI_W){1'b0}}, len_r};
    else if (addr == `IMU_REG_CMD)
      rd_mux = {29'h0000_0000, susp_r, 2'b00};
    else if (addr == `IMU_REG_STATUS)
      rd_mux = {30'h0000_0000, nack_r, state_r != IMU_C_IDLE};
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata <= 32'h0000_0000;
    else if (ce)
      rdata <= rd ? rd_mux : 32'h0000_0000;
  end

  // ==========================================================
  // Bit sequencer; SCL is a divided copy of clk
  logic [1:0] sda_sync_r;
  logic sda_s;
  logic [15:0] tmr_r;
  logic [1:0] step_r;
  logic [3:0] bit_r;
  logic [4:0] byte_r;
  logic [RXI_W-1:0] rx_idx_r;
  imu_byte_t sh_r;
  imu_byte_t nxt_byte;
  logic rd_op_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic tdone;
  logic rx_ph;
  logic rx_last;

  assign sda_s = sda_sync_r[1];
  assign tdone = (tmr_r == 16'h0000);
  assign rx_ph = rd_op_r & (byte_r >= 5'd3);
  assign rx_last = (rx_idx_r == len_r);
  assign nack_ev = ce & (state_r == IMU_C_BIT) & tdone & (step_r == 2'd1)
                   & (bit_r == 4'd8) & ~rx_ph & sda_s;
  always_comb
  begin
    nxt_byte = ptr_r;
    if (state_r == IMU_C_START)
      nxt_byte = {tgt_r, 1'b0};
    else if (state_r == IMU_C_RSTART)
      nxt_byte = {tgt_r, 1'b1};
    else if (byte_r == 5'd1)
      nxt_byte = wdat_r;
  end

  // Clock stretching is not supported; the bus is timed from clk alone
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sda_sync_r <= 2'b11;
      state_r <= IMU_C_IDLE;
      tmr_r <= 16'h0000;
      step_r <= 2'd0;
      bit_r <= 4'h0;
      byte_r <= 5'd0;
      rx_idx_r <= '0;
      sh_r <= 8'h00;
      rd_op_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (ce)
    begin
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      if (!tdone)
        tmr_r <= tmr_r - 16'h0001;
      unique case (state_r)
        IMU_C_IDLE:
          if (go_wr || go_rd)
          begin
            rd_op_r <= go_rd;
            sda_oe_r <= 1'b1;
            tmr_r <= HIGH_C;
            state_r <= IMU_C_START;
          end
        IMU_C_START, IMU_C_RSTART:
          if (tdone && state_r == IMU_C_RSTART && step_r == 2'd0)
          begin
            scl_oe_r <= 1'b0;
            tmr_r <= HIGH_C;
            step_r <= 2'd1;
          end
          else if (tdone && state_r == IMU_C_RSTART && step_r == 2'd1)
          begin
            sda_oe_r <= 1'b1;
            tmr_r <= HIGH_C;
            step_r <= 2'd2;
          end
          else if (tdone)
          begin
            // Address always follows, so no bare start-stop pair goes out
            scl_oe_r <= 1'b1;
            sh_r <= nxt_byte;
            sda_oe_r <= ~nxt_byte[7];
            bit_r <= 4'h0;
            step_r <= 2'd0;
            tmr_r <= LOW_C;
            byte_r <= (state_r == IMU_C_RSTART) ? 5'd2 : 5'd0;
            state_r <= IMU_C_BIT;
          end
        IMU_C_BIT:
          if (tdone && step_r == 2'd0)
          begin
            scl_oe_r <= 1'b0;
            tmr_r <= HIGH_C;
            step_r <= 2'd1;
          end
          else if (tdone)
          begin
            scl_oe_r <= 1'b1;
            step_r <= 2'd0;
            tmr_r <= LOW_C;
            bit_r <= bit_r + 4'h1;
            if (bit_r < 4'd8)
              sh_r <= {sh_r[6:0], sda_s};
            if (bit_r < 4'd7)
              sda_oe_r <= ~rx_ph & ~sh_r[6];
            else if (bit_r == 4'd7)
            begin
              sda_oe_r <= rx_ph & ~rx_last;
              if (rx_ph)
                rxbuf_r[rx_idx_r] <= {sh_r[6:0], sda_s};
            end
            else if (nack_ev || (rx_ph && rx_last) || (!rd_op_r && byte_r == 5'd2))
            begin
              sda_oe_r <= 1'b1;
              state_r <= IMU_C_STOP;
            end
            else if (rd_op_r && byte_r == 5'd1)
            begin
              sda_oe_r <= 1'b0;
              state_r <= IMU_C_RSTART;
            end
            else if (rd_op_r && byte_r >= 5'd2)
            begin
              sda_oe_r <= 1'b0;
              bit_r <= 4'h0;
              byte_r <= byte_r + 5'd1;
              rx_idx_r <= rx_ph ? rx_idx_r + 1'b1 : '0;
            end
            else
            begin
              sh_r <= nxt_byte;
              sda_oe_r <= ~nxt_byte[7];
              bit_r <= 4'h0;
              byte_r <= byte_r + 5'd1;
            end
          end
        IMU_C_STOP:
          if (tdone && step_r == 2'd0)
          begin
            scl_oe_r <= 1'b0;
            tmr_r <= HIGH_C;
            step_r <= 2'd1;
          end
          else if (tdone && step_r == 2'd1)
          begin
            sda_oe_r <= 1'b0;
            tmr_r <= BUF_C;
            step_r <= 2'd2;
          end
          else if (tdone)
          begin
            step_r <= 2'd0;
            tmr_r <= susp_r ? SUM_C : NM_C;
            state_r <= rd_op_r ? IMU_C_IDLE : IMU_C_GAP;
          end
        IMU_C_GAP:
          if (tdone)
            state_r <= IMU_C_IDLE;
        default:
          state_r <= IMU_C_IDLE;
      endcase
    end
  end

  assign bus.ctl_scl_oe = scl_oe_r;
  assign bus.ctl_scl_out = 1'b0;
  assign bus.ctl_sda_oe = sda_oe_r;
  assign bus.ctl_sda_out = 1'b0;
endmodule : imu_i2c_controller

/* File: bench/imu_i2c_chk.sv */
module imu_i2c_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_scl_out,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_out,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_out,
  input wire logic tgt_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Wire checks, all sampled on the system clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_tgt_low_only: assert property (tgt_sda_out == 1'b0)
    else $error("target drove sda high");
  chk_ctl_low_only: assert property (!ctl_sda_out && !ctl_scl_out)
    else $error("controller drove a line high");
  chk_ack_steady: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe))
    else $error("target moved sda while scl high");
  chk_no_contention: assert property (scl && tgt_sda_oe |-> !ctl_sda_oe && !sda)
    else $error("both ends own sda in scl high");
  chk_start_hold: assert property ($rose(ctl_sda_oe) && scl |-> scl [*8])
    else $error("start hold too short");
  chk_stop_setup: assert property ($fell(ctl_sda_oe) && scl |-> $past(scl, 8))
    else $error("stop setup too short");
  chk_scl_low: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low period too short");
  chk_scl_high: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high period too short");
endmodule : imu_i2c_chk

/* File: bench/imu_i2c_target_interface_tb_top.sv */
`include "imu_i2c_params.svh"

module imu_i2c_target_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import imu_i2c_pkg::*;

  logic clk, link_clk, rst_b, wr, rd, wr_valid, wr_part, bus_busy, accel_spi_mode;
  logic accel_addr_select, gyro_addr_select, accel_chip_select_n, gyro_protocol_select;
  logic [7:0] addr, wr_addr;
  logic [31:0] wdata, rdata, rv, seed;
  imu_byte_t wr_data;
  imu_byte_t mem [2][256] = '{default: 8'h00};
  logic [6:0] tab [4] = '{`IMU_ACC_ADDR_LO, `IMU_ACC_ADDR_HI, `IMU_GYR_ADDR_LO, `IMU_GYR_ADDR_HI};
  int err_total, samples_checked, wr_seen, cyc;
  logic [7:0] b;

  imu_i2c_if bus_if ();
  imu_i2c_controller #(.WACC_SUM_CYC(200)) imu_i2c_controller_i (.clk(clk), .rst_b(rst_b),
    .ce(1'b1), .bus(bus_if), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  imu_i2c_target imu_i2c_target_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .link_clk(link_clk),
    .bus(bus_if), .accel_addr_select(accel_addr_select), .gyro_addr_select(gyro_addr_select),
    .accel_chip_select_n(accel_chip_select_n), .gyro_protocol_select(gyro_protocol_select),
    .wr_valid(wr_valid), .wr_part(wr_part), .wr_addr(wr_addr), .wr_data(wr_data),
    .bus_busy(bus_busy), .accel_spi_mode(accel_spi_mode));
  imu_i2c_chk imu_i2c_chk_i (.clk(clk), .rst_b(rst_b), .scl(bus_if.scl), .sda(bus_if.sda),
    .ctl_scl_out(bus_if.ctl_scl_out), .ctl_scl_oe(bus_if.ctl_scl_oe),
    .ctl_sda_out(bus_if.ctl_sda_out), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .tgt_sda_out(bus_if.tgt_sda_out), .tgt_sda_oe(bus_if.tgt_sda_oe));

  // ==========================================
  // Clocks; link clock offset so phases never line up
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Stored-write counter and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1)
      wr_seen <= wr_seen + 1;
    if (cyc == 90000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rreg

  // Full transfer; busy is polled through the write gap, then a margin lets bus_busy settle
  task automatic go(logic [6:0] t, logic [7:0] p, logic [7:0] d, logic [2:0] c, logic [3:0] l);
    int n;
    wreg(`IMU_REG_STATUS, 32'h2);
    wreg(`IMU_REG_TARGET, {25'h0, t});
    wreg(`IMU_REG_PTR, {24'h0, p});
    wreg(`IMU_REG_WDATA, {24'h0, d});
    wreg(`IMU_REG_LEN, {28'h0, l});
    wreg(`IMU_REG_CMD, {29'h0, c});
    repeat (150) @(posedge clk);
    check("busy", 8'(bus_busy), 8'h1);
    n = 0;
    rreg(`IMU_REG_STATUS);
    while (rv[`IMU_STAT_BUSY_BIT] !== 1'b0 && n < 5000)
    begin
      n++;
      rreg(`IMU_REG_STATUS);
    end
    repeat (100) @(posedge clk);
    check("idle", 8'(bus_busy), 8'h0);
    rreg(`IMU_REG_STATUS);
    check("done", 8'(rv[`IMU_STAT_BUSY_BIT]), 8'h0);
  endtask : go

  task automatic wr_one(logic [6:0] t, logic [7:0] p, logic hit);
    int n0;
    n0 = wr_seen;
    void'(xs());
    go(t, p, seed[7:0], {seed[8], 2'b01}, 4'h0);
    check("nack", 8'(rv[`IMU_STAT_NACK_BIT]), 8'(!hit));
    check("stores", 8'(wr_seen - n0), 8'(hit));
    rreg(`IMU_REG_CMD);
    check("susp", 8'(rv[`IMU_CMD_SUSP_BIT]), 8'(seed[8]));
    if (hit)
    begin
      check("part", 8'(wr_part), 8'(t[6]));
      check("waddr", wr_addr, p);
      check("wdata", wr_data, seed[7:0]);
      mem[t[6]][p] = seed[7:0];
    end
  endtask : wr_one

  task automatic rd_chk(logic [6:0] t, logic [7:0] p);
    go(t, p, 8'h00, 3'b010, 4'h3);
    check("rd nack", 8'(rv[`IMU_STAT_NACK_BIT]), 8'h0);
    for (int k = 0; k < 4; k++)
    begin
      rreg(8'(`IMU_REG_RXBUF + 4 * k));
      check("rxbyte", rv[7:0], mem[t[6]][8'(p + k)]);
    end
  endtask : rd_chk

  // ==========================================
  // Main sequence
  initial
  begin
    seed = 32'h5d0034f0;
    {rst_b, wr, rd, addr, wdata, err_total, samples_checked, wr_seen, cyc} = '0;
    {accel_addr_select, gyro_addr_select} = 2'b00;
    {accel_chip_select_n, gyro_protocol_select} = 2'b11;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    check("spi mode", 8'(accel_spi_mode), 8'h0);
    for (int i = 0; i < 4; i++)
    begin
      accel_addr_select <= i[0];
      gyro_addr_select <= i[0];
      repeat (10) @(posedge clk);
      void'(xs());
      wr_one(tab[i], seed[15:8], 1'b1);
      wr_one(tab[i] ^ 7'h01, 8'h00, 1'b0);
      $display("strap test %0d done", i);
    end
    void'(xs());
    b = seed[7:0];
    for (int k = 0; k < 4; k++)
      wr_one(tab[1], 8'(b + k), 1'b1);
    rd_chk(tab[1], b);
    rd_chk(tab[1], b);
    rd_chk(tab[3], b);
    $display("burst test done");
    gyro_protocol_select <= 1'b0;
    accel_chip_select_n <= 1'b0;
    repeat (10) @(posedge clk);
    accel_chip_select_n <= 1'b1;
    repeat (10) @(posedge clk);
    check("spi mode", 8'(accel_spi_mode), 8'h1);
    wr_one(tab[3], 8'h00, 1'b0);
    wr_one(tab[1], 8'h00, 1'b0);
    $display("mode test done");
    wrap_up();
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
endmodule : imu_i2c_target_interface_tb_top
